// File: tcw_defs.svh
// register indices, field positions, reset values and timing counts of the timer compare block
`ifndef TCW_DEFS_SVH
`define TCW_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define TCW_IDX_MODE        16'hff80
`define TCW_IDX_CTRL        16'hff81
`define TCW_IDX_IRQ_EN      16'hff82
`define TCW_IDX_STATUS      16'hff83
`define TCW_IDX_COUNT       16'hff86
`define TCW_IDX_PERIOD      16'hff88
`define TCW_IDX_WIDTH       16'hff8a

// mode register fields
`define TCW_MODE_START_BIT  7
`define TCW_MODE_PULSE_BIT  0
// control register fields
`define TCW_CTRL_CLEAR_BIT  7
`define TCW_CTRL_LEVEL_BIT  1
// status and enable fields share one layout
`define TCW_OVF_BIT         7
`define TCW_MATCH_D_BIT     3
`define TCW_MATCH_C_BIT     2
`define TCW_MATCH_B_BIT     1
`define TCW_MATCH_A_BIT     0
`define TCW_FLAG_MASK       8'h8f

// reset values
`define TCW_RST_BYTE        8'h00
`define TCW_RST_WORD        16'h0000
`define TCW_RST_COUNT_TOP   16'hffff
`define TCW_RST_BUS         32'h0000_0000

// counter input clock is the system clock divided by this
`define TCW_PRESCALE        8

`endif

// File: tcw_pkg.sv
// shared types of the timer compare block
package tcw_pkg;
  typedef logic [7:0]  tcw_byte_t;
  typedef logic [15:0] tcw_count_t;
  typedef logic [31:0] tcw_bus_t;
endpackage

// File: tcw_timer.sv
// timer compare block: prescaled up-counter, two compare matches, status flags, interrupts, waveform pin
`include "tcw_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tcw_timer #(
  parameter int ADR_W    = 18,
  parameter int PRESCALE = `TCW_PRESCALE
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [ADR_W-1:0]   adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire tcw_pkg::tcw_bus_t  dat_i,
  output logic                    ack_o,
  output tcw_pkg::tcw_bus_t       dat_o,
  // interrupt requests
  output tcw_pkg::tcw_byte_t      irq_req_o,
  output logic                    irq_o,
  // waveform pin
  output logic                    waveform_out_b_o
);
  import tcw_pkg::*;

  localparam int PRE_W = $clog2(PRESCALE);

  // software-visible state
  logic       counter_start;
  logic       pulse_mode_b;
  logic       clear_on_match_a;
  logic       initial_level_b;
  tcw_byte_t  irq_enable_bits;
  tcw_byte_t  timer_flag_status;
  tcw_count_t up_count_value;
  tcw_count_t period_match_value;
  tcw_count_t width_match_value;

  // internal state and events
  logic [PRE_W-1:0] prescale_cnt;
  logic             tick;
  logic             step;
  logic             match_a;
  logic             match_b;
  logic             wrap;
  logic             access;
  logic             wr;
  logic [15:0]      idx;
  logic             hit;
  tcw_bus_t         next_dat;
  tcw_byte_t        set_bits;
  tcw_byte_t        clr_bits;
  tcw_byte_t        next_status;

  // ---------------------------------------------------------------
  // bus slave: ack one cycle after the request, write at the ack edge
  // ---------------------------------------------------------------
  assign idx    = adr_i[17:2];
  assign access = cyc_i && stb_i && ack_o;
  assign wr     = access && we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  always_comb begin
    next_dat = `TCW_RST_BUS;
    hit      = 1'b1;
    unique case (idx)
      `TCW_IDX_MODE: begin
        next_dat[`TCW_MODE_START_BIT] = counter_start;
        next_dat[`TCW_MODE_PULSE_BIT] = pulse_mode_b;
      end
      `TCW_IDX_CTRL: begin
        next_dat[`TCW_CTRL_CLEAR_BIT] = clear_on_match_a;
        next_dat[`TCW_CTRL_LEVEL_BIT] = initial_level_b;
      end
      `TCW_IDX_IRQ_EN:  next_dat[7:0]  = irq_enable_bits;
      `TCW_IDX_STATUS:  next_dat[7:0]  = timer_flag_status;
      `TCW_IDX_COUNT:   next_dat[15:0] = up_count_value;
      `TCW_IDX_PERIOD:  next_dat[15:0] = period_match_value;
      `TCW_IDX_WIDTH:   next_dat[15:0] = width_match_value;
      default:          hit            = 1'b0;
    endcase
  end

  // unmapped reads return zero; read data is launched with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= `TCW_RST_BUS;
    end else if (cyc_i && stb_i && !ack_o && !we_i && hit) begin
      dat_o <= next_dat;
    end else begin
      dat_o <= `TCW_RST_BUS;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_start    <= 1'b0;
      pulse_mode_b     <= 1'b0;
      clear_on_match_a <= 1'b0;
      initial_level_b  <= 1'b0;
      irq_enable_bits  <= `TCW_RST_BYTE;
    end else if (wr && sel_i[0]) begin
      if (idx == `TCW_IDX_MODE) begin
        counter_start <= dat_i[`TCW_MODE_START_BIT];
        pulse_mode_b  <= dat_i[`TCW_MODE_PULSE_BIT];
      end
      if (idx == `TCW_IDX_CTRL) begin
        clear_on_match_a <= dat_i[`TCW_CTRL_CLEAR_BIT];
        initial_level_b  <= dat_i[`TCW_CTRL_LEVEL_BIT];
      end
      if (idx == `TCW_IDX_IRQ_EN) begin
        irq_enable_bits <= dat_i[7:0] & `TCW_FLAG_MASK;
      end
    end
  end

  // compare registers take each byte lane on its own
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_match_value <= `TCW_RST_WORD;
      width_match_value  <= `TCW_RST_WORD;
    end else if (wr) begin
      if (idx == `TCW_IDX_PERIOD) begin
        if (sel_i[0]) period_match_value[7:0]  <= dat_i[7:0];
        if (sel_i[1]) period_match_value[15:8] <= dat_i[15:8];
      end
      if (idx == `TCW_IDX_WIDTH) begin
        if (sel_i[0]) width_match_value[7:0]  <= dat_i[7:0];
        if (sel_i[1]) width_match_value[15:8] <= dat_i[15:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // prescaler and counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale_cnt <= '0;
    end else if (tick) begin
      prescale_cnt <= '0;
    end else begin
      prescale_cnt <= prescale_cnt + PRE_W'(1);
    end
  end

  assign tick    = (prescale_cnt == PRE_W'(PRESCALE - 1));
  assign step    = tick && counter_start;
  assign match_a = step && (up_count_value == period_match_value);
  assign match_b = step && (up_count_value == width_match_value);
  assign wrap    = step && !(match_a && clear_on_match_a) && (up_count_value == `TCW_RST_COUNT_TOP);

  // a software write to the counter wins over counting in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_count_value <= `TCW_RST_WORD;
    end else if (wr && idx == `TCW_IDX_COUNT && sel_i[1:0] != 2'b00) begin
      if (sel_i[0]) up_count_value[7:0]  <= dat_i[7:0];
      if (sel_i[1]) up_count_value[15:8] <= dat_i[15:8];
    end else if (match_a && clear_on_match_a) begin
      up_count_value <= `TCW_RST_WORD;
    end else if (step) begin
      up_count_value <= up_count_value + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // status flags: a set in the clearing cycle survives
  // ---------------------------------------------------------------
  always_comb begin
    set_bits = `TCW_RST_BYTE;
    set_bits[`TCW_MATCH_A_BIT] = match_a;
    set_bits[`TCW_MATCH_B_BIT] = match_b;
    set_bits[`TCW_OVF_BIT]     = wrap;
    clr_bits = `TCW_RST_BYTE;
    if (wr && sel_i[0] && idx == `TCW_IDX_STATUS) begin
      clr_bits = ~dat_i[7:0] & `TCW_FLAG_MASK;
    end
    next_status = (timer_flag_status & ~clr_bits) | set_bits;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_flag_status <= `TCW_RST_BYTE;
    end else begin
      timer_flag_status <= next_status;
    end
  end

  // compare C and D have no datapath here, so their flags only ever clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o <= `TCW_RST_BYTE;
      irq_o     <= 1'b0;
    end else begin
      irq_req_o <= timer_flag_status & irq_enable_bits;
      irq_o     <= |(timer_flag_status & irq_enable_bits);
    end
  end

  // ---------------------------------------------------------------
  // waveform pin
  // ---------------------------------------------------------------
  // the level is reloaded while stopped so a restart begins from a known phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waveform_out_b_o <= 1'b0;
    end else if (!counter_start) begin
      waveform_out_b_o <= initial_level_b;
    end else if (match_b) begin
      waveform_out_b_o <= ~initial_level_b;
    end else if (pulse_mode_b && match_a) begin
      waveform_out_b_o <= initial_level_b;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ovf_gate_a: assert property (
    (timer_flag_status[`TCW_OVF_BIT] && !irq_enable_bits[`TCW_OVF_BIT]) |=> !irq_req_o[`TCW_OVF_BIT])
    else $error("overflow request passed while disabled");

  ovf_flag_free_a: assert property (
    (wrap && !irq_enable_bits[`TCW_OVF_BIT]) |=> timer_flag_status[`TCW_OVF_BIT])
    else $error("overflow flag depends on its enable");

  cmp_d_gate_a: assert property (
    irq_req_o[`TCW_MATCH_D_BIT] |-> $past(irq_enable_bits[`TCW_MATCH_D_BIT]))
    else $error("compare d request without enable");

  cmp_c_gate_a: assert property (
    irq_req_o[`TCW_MATCH_C_BIT] |-> $past(irq_enable_bits[`TCW_MATCH_C_BIT]))
    else $error("compare c request without enable");

  cmp_b_gate_a: assert property (
    irq_req_o[`TCW_MATCH_B_BIT] |-> $past(irq_enable_bits[`TCW_MATCH_B_BIT] && timer_flag_status[1]))
    else $error("compare b request without enable or flag");

  cmp_a_gate_a: assert property (
    (timer_flag_status[`TCW_MATCH_A_BIT] && irq_enable_bits[`TCW_MATCH_A_BIT]) |=> irq_req_o[0] && irq_o)
    else $error("compare a request not raised");

  match_b_flag_a: assert property (
    $rose(timer_flag_status[`TCW_MATCH_B_BIT]) |-> $past(step && up_count_value == width_match_value))
    else $error("match b flag set without match");

  match_a_flag_a: assert property (
    (step && up_count_value == period_match_value) |=> timer_flag_status[`TCW_MATCH_A_BIT])
    else $error("match a flag missed");

  count_step_a: assert property (
    (step && !wr && !(match_a && clear_on_match_a)) |=> up_count_value == $past(up_count_value) + 16'h0001)
    else $error("counter did not step by one");

  tick_space_a: assert property (
    tick |=> !tick [*7] ##1 tick)
    else $error("counter tick not every eight clocks");

  clear_match_a: assert property (
    (match_a && clear_on_match_a && !wr) |=> up_count_value == `TCW_RST_WORD)
    else $error("counter not cleared on match a");

  stop_hold_a: assert property (
    (!counter_start && !wr) |=> $stable(up_count_value))
    else $error("counter moved while stopped");

  level_hold_a: assert property (
    !counter_start |=> waveform_out_b_o == $past(initial_level_b))
    else $error("waveform not at initial level while stopped");

  pulse_edge_a: assert property (
    (counter_start && pulse_mode_b && match_a && !match_b) |=> waveform_out_b_o == $past(initial_level_b))
    else $error("pulse period edge wrong");

  flag_clear_a: assert property (
    (wr && sel_i[0] && idx == `TCW_IDX_STATUS && dat_i[1] && !match_b) |=>
      timer_flag_status[1] == $past(timer_flag_status[1]))
    else $error("written one changed a flag");

  // flags are sticky: without a status write no set bit may fall
  flag_sticky_a: assert property (
    !(wr && sel_i[0] && idx == `TCW_IDX_STATUS) |=>
      (timer_flag_status & $past(timer_flag_status)) == $past(timer_flag_status))
    else $error("status flag fell without a clear");

  ovf_wrap_a: assert property (
    (step && !clear_on_match_a && !wr && up_count_value == `TCW_RST_COUNT_TOP) |=>
      (timer_flag_status[`TCW_OVF_BIT] && up_count_value == `TCW_RST_WORD))
    else $error("counter wrap did not set overflow");

  irq_idle_a: assert property (
    (timer_flag_status == `TCW_RST_BYTE) |=> (!irq_o && irq_req_o == `TCW_RST_BYTE))
    else $error("request raised with no flag set");

  pin_match_b_a: assert property (
    match_b |=> waveform_out_b_o != $past(initial_level_b))
    else $error("waveform did not leave initial level on match b");

  cmp_b_off_a: assert property (
    !irq_enable_bits[`TCW_MATCH_B_BIT] |=> !irq_req_o[`TCW_MATCH_B_BIT])
    else $error("compare b request while disabled");

  cmp_a_off_a: assert property (
    !irq_enable_bits[`TCW_MATCH_A_BIT] |=> !irq_req_o[`TCW_MATCH_A_BIT])
    else $error("compare a request while disabled");

endmodule

`default_nettype wire

// File: tcw_load.sv
// external load on the waveform pin: measures high width and period in clock cycles
`timescale 1ns/1ps
`default_nettype none

module tcw_load (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // pin and measurements
  input  wire logic        level_i,
  output logic [15:0]      high_len_o,
  output logic [15:0]      period_len_o
);
  logic        prev;
  logic [15:0] since_rise;

  // a pure listener; it never drives the pin, so no enable logic is needed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev         <= 1'b0;
      since_rise   <= 16'h0000;
      high_len_o   <= 16'h0000;
      period_len_o <= 16'h0000;
    end else begin
      prev <= level_i;
      if (level_i && !prev) begin
        period_len_o <= since_rise;
        since_rise   <= 16'h0001;
      end else begin
        since_rise <= since_rise + 16'h0001;
      end
      if (!level_i && prev) begin
        high_len_o <= since_rise;
      end
    end
  end
endmodule

`default_nettype wire

// File: timer_compare_irq_status_bench.sv
// self-checking bench: bus access, flags, interrupt gating, counter rate, waveform pin
`include "tcw_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module timer_compare_irq_status_bench;
  import tcw_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [17:0] adr_i = 18'h0_0000;
  logic [3:0]  sel_i = 4'h0;
  tcw_bus_t    dat_i = 32'h0000_0000;
  logic        ack_o;
  tcw_bus_t    dat_o;
  tcw_byte_t   irq_req_o;
  logic        irq_o;
  logic        waveform_out_b_o;
  logic [15:0] high_len;
  logic [15:0] period_len;
  logic [15:0] rd;
  logic [15:0] rd2;
  int          mismatches = 0;
  int          num_checks = 0;

  always #5 clk_i = ~clk_i;

  tcw_timer tcw_timer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o), .irq_req_o(irq_req_o),
    .irq_o(irq_o), .waveform_out_b_o(waveform_out_b_o)
  );

  tcw_load tcw_load_inst (
    .clk_i(clk_i), .rst_i(rst_i), .level_i(waveform_out_b_o),
    .high_len_o(high_len), .period_len_o(period_len)
  );

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic clks(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // request held until ack is sampled high; the slave's latency is not assumed
  task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h3;
    dat_i <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) begin
      mismatches++;
      $display("wrong value ack expected 1 seen 0");
      tally_and_finish();
    end
    q = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rdchk(input string what, input logic [15:0] idx, input logic [15:0] exp);
    logic [15:0] q;
    wb(1'b0, idx, 16'h0000, q);
    chk(what, q, exp);
  endtask

  task automatic reset_values;
    rdchk("status", `TCW_IDX_STATUS, 16'h0000);
    rdchk("count", `TCW_IDX_COUNT, 16'h0000);
    rdchk("irq enable", `TCW_IDX_IRQ_EN, 16'h0000);
    wr(16'hff84, 16'h00ff);
    rdchk("unmapped", 16'hff84, 16'h0000);
    chk("pin at reset", {15'h0000, waveform_out_b_o}, 16'h0000);
  endtask

  // period 3, width 1, clear on match A: four ticks a period, high from count 1 to 3
  task automatic pwm_run;
    wr(`TCW_IDX_PERIOD, 16'h0003);
    wr(`TCW_IDX_WIDTH, 16'h0001);
    wr(`TCW_IDX_CTRL, 16'h0080);
    wr(`TCW_IDX_MODE, 16'h0081);
    clks(240);
    chk("pulse high width", high_len, 16'd16);
    chk("pulse period", period_len, 16'd32);
    rdchk("match flags", `TCW_IDX_STATUS, 16'h0003);
    chk("gated requests", {8'h00, irq_req_o}, 16'h0000);
    wr(`TCW_IDX_IRQ_EN, 16'h0001);
    clks(3);
    chk("request a", {8'h00, irq_req_o}, 16'h0001);
    wr(`TCW_IDX_IRQ_EN, 16'h0002);
    clks(3);
    chk("request b", {8'h00, irq_req_o}, 16'h0002);
    chk("irq line", {15'h0000, irq_o}, 16'h0001);
    wr(`TCW_IDX_MODE, 16'h0000);
    wr(`TCW_IDX_STATUS, 16'h0003);
    rdchk("flags kept", `TCW_IDX_STATUS, 16'h0003);
    wr(`TCW_IDX_STATUS, 16'h0001);
    rdchk("flag b cleared", `TCW_IDX_STATUS, 16'h0001);
    clks(3);
    chk("irq line cleared", {15'h0000, irq_o}, 16'h0000);
    wr(`TCW_IDX_STATUS, 16'h0000);
    wr(`TCW_IDX_IRQ_EN, 16'h0000);
  endtask

  task automatic level_hold;
    wr(`TCW_IDX_CTRL, 16'h0002);
    wr(`TCW_IDX_WIDTH, 16'h0100);
    wr(`TCW_IDX_PERIOD, 16'h0200);
    wr(`TCW_IDX_MODE, 16'h0080);
    clks(40);
    chk("initial level held", {15'h0000, waveform_out_b_o}, 16'h0001);
    wr(`TCW_IDX_MODE, 16'h0000);
    wr(`TCW_IDX_CTRL, 16'h0000);
  endtask

  task automatic overflow_gate;
    wr(`TCW_IDX_COUNT, 16'hfffe);
    wr(`TCW_IDX_IRQ_EN, 16'h000c);
    wr(`TCW_IDX_MODE, 16'h0080);
    clks(40);
    wr(`TCW_IDX_MODE, 16'h0000);
    rdchk("overflow flag", `TCW_IDX_STATUS, 16'h0080);
    chk("c d and masked overflow", {8'h00, irq_req_o}, 16'h0000);
    wr(`TCW_IDX_IRQ_EN, 16'h0080);
    clks(3);
    chk("overflow request", {8'h00, irq_req_o}, 16'h0080);
    wr(`TCW_IDX_STATUS, 16'h0000);
    wr(`TCW_IDX_IRQ_EN, 16'h0000);
  endtask

  // reads 80 cycles apart with the same bus latency, so exactly ten ticks lie between
  task automatic count_rate;
    wb(1'b0, `TCW_IDX_COUNT, 16'h0000, rd);
    clks(40);
    rdchk("stopped count", `TCW_IDX_COUNT, rd);
    wr(`TCW_IDX_MODE, 16'h0080);
    wb(1'b0, `TCW_IDX_COUNT, 16'h0000, rd);
    clks(77);
    wb(1'b0, `TCW_IDX_COUNT, 16'h0000, rd2);
    wr(`TCW_IDX_MODE, 16'h0000);
    chk("count step", rd2 - rd, 16'd10);
  endtask

  initial begin
    clks(10);
    rst_i <= 1'b0;
    reset_values();
    pwm_run();
    level_hold();
    overflow_gate();
    count_rate();
    // second reset in mid-run: status, count, interrupt enable and the pin must come back to their reset values
    rst_i <= 1'b1;
    clks(10);
    rst_i <= 1'b0;
    reset_values();
    tally_and_finish();
  end
endmodule

`default_nettype wire
